// >>> rtl/hisp_pkg.sv
/*
 * Holds the constants, types and decode functions of the host interface select port.
 * Assumes it is compiled before every file that imports it.
 */
// Operation
// - Straps 00X pick 8080, 01X 6800, 100 3-wire SPI, 101 4-wire SPI, 11X I2C.
// - In parallel modes the lowest strap pin becomes an external interrupt input.
// - Upper eight data lines are a general-purpose port unless 16-bit bus is set in a parallel mode.
// - In serial modes lower eight data lines serve the serial host pins.
// - Parallel cycles are answered only while chip select is low.
// - In 8080 mode the read pin is an active-low read request.
// - In 6800 mode the read pin is an active-high enable strobe.
// - In 8080 mode the write pin is an active-low write request.
// - In 6800 mode the write pin selects direction: high read, low write.
// - Command/data select low means status read or command write.
// - Command/data select high means data read or data write.
// - In serial modes chip select, read, write, select become inputs zero to three.
// - An interrupt output pin tells the host about status conditions.
// - Wait output is high when ready to finish a transfer, low otherwise.
`default_nettype none
package hisp_pkg;

    // ---------------------------------------------------------------
    // Widths and counts
    // ---------------------------------------------------------------
    localparam int unsigned HISP_DATA_W = 16;
    localparam int unsigned HISP_BYTE_W = 8;
    localparam int unsigned HISP_SYNC_W = 23;
    localparam logic [1:0] HISP_STRAP_SETTLE = 2'h3; // Cycles after release before sampling
    localparam logic [7:0] HISP_BYTE_HIZ = 8'hff;    // Enables high: pins released

    // ---------------------------------------------------------------
    // Positions inside the synchronised input vector
    // ---------------------------------------------------------------
    localparam int unsigned HISP_POS_DATA = 0;
    localparam int unsigned HISP_POS_CS = 16;
    localparam int unsigned HISP_POS_RD = 17;
    localparam int unsigned HISP_POS_WR = 18;
    localparam int unsigned HISP_POS_CD = 19;
    localparam int unsigned HISP_POS_STRAP = 20;

    // ---------------------------------------------------------------
    // Strap codes of the two upper strap bits
    // ---------------------------------------------------------------
    localparam logic [1:0] HISP_STRAP_8080 = 2'h0;
    localparam logic [1:0] HISP_STRAP_6800 = 2'h1;
    localparam logic [1:0] HISP_STRAP_SPI = 2'h2;
    localparam logic [1:0] HISP_STRAP_I2C = 2'h3;

    typedef enum logic [2:0] {
        HISP_MODE_8080,
        HISP_MODE_6800,
        HISP_MODE_SPI3,
        HISP_MODE_SPI4,
        HISP_MODE_I2C
    } hisp_mode_t;

    typedef enum logic [1:0] {
        HISP_ST_IDLE,
        HISP_ST_ACCESS,
        HISP_ST_HOLD
    } hisp_state_t;

    // Strap value to host mode
    function automatic hisp_mode_t hisp_decode(input logic [2:0] straps);
        hisp_mode_t m;
        m = HISP_MODE_8080;
        case (straps[2:1])
            HISP_STRAP_8080: m = HISP_MODE_8080;
            HISP_STRAP_6800: m = HISP_MODE_6800;
            HISP_STRAP_SPI: m = straps[0] ? HISP_MODE_SPI4 : HISP_MODE_SPI3;
            HISP_STRAP_I2C: m = HISP_MODE_I2C;
            default: m = HISP_MODE_8080;
        endcase
        return m;
    endfunction

    // True for the two parallel bus modes
    function automatic logic hisp_is_par(input hisp_mode_t m);
        return (m == HISP_MODE_8080) || (m == HISP_MODE_6800);
    endfunction

endpackage
`default_nettype wire

// >>> rtl/hisp_sync.sv
/*
 * Holds a two-stage synchroniser for a vector of asynchronous pins.
 * Assumes each bit is an independent level; multi-bit words are only read while stable.
 */
`timescale 1ns/1ps
`default_nettype none
module hisp_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic mclk_in,              // System clock
    input wire logic resetn_in,            // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] async_in, // Pin levels
    output logic [WIDTH-1:0] sync_out      // Synchronised levels
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Refuse an empty vector at elaboration
    if (WIDTH < 1) begin : g_width_check
        $error("hisp_sync: WIDTH must be at least 1");
    end

    // ---------------------------------------------------------------
    // Two flip-flops; the first is read only by the second
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule
`default_nettype wire

// >>> rtl/hisp_port.sv
/*
 * Holds the host pin logic: strap decode, parallel 8080/6800 cycle engine with wait,
 * pin sharing for serial modes and the upper-byte general-purpose port.
 * Assumes all pin inputs are asynchronous and the core side runs on mclk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module hisp_port
    import hisp_pkg::*;
(
    input wire logic mclk_in,                      // 50 MHz system clock
    input wire logic resetn_in,                    // Asynchronous reset, active low
    input wire logic [2:0] host_mode_straps_in,    // Mode strap pins
    input wire logic host_cs_n_in,                 // Chip select pin, active low
    input wire logic host_rd_in,                   // Read or enable pin
    input wire logic host_wr_in,                   // Write or direction pin
    input wire logic cmd_data_select_in,           // Command/data select pin
    input wire logic [15:0] host_data_bus_in,      // Data bus pin levels
    output logic [15:0] host_data_bus_out,         // Data bus drive values
    output logic [15:0] host_data_bus_oe_n_out,    // Data bus enables, low drives
    output logic wait_out,                         // Wait pin, high when ready
    output logic int_n_out,                        // Interrupt pin, active low
    input wire logic irq_req_in,                   // Core interrupt request
    input wire logic bus16_en_in,                  // 16-bit parallel bus configured
    output logic [2:0] host_mode_out,              // Selected mode code
    output logic mode_valid_out,                   // Mode has been sampled
    output logic ext_irq_out,                      // External interrupt level
    input wire logic core_ready_in,                // Core can complete a transfer
    input wire logic [15:0] status_in,             // Status word for status reads
    input wire logic [15:0] rd_data_in,            // Data word for data reads
    output logic cmd_wr_out,                       // Command write pulse
    output logic data_wr_out,                      // Data write pulse
    output logic status_rd_out,                    // Status read pulse
    output logic data_rd_out,                      // Data read pulse
    output logic [15:0] wr_data_out,               // Write word
    output logic [3:0] aux_input_port_out,         // Auxiliary inputs in serial modes
    output logic [7:0] upper_bus_io_port_out,      // Upper byte input levels
    input wire logic [7:0] upper_bus_io_port_in,   // Upper byte drive values
    input wire logic [7:0] upper_bus_io_oe_n_in,   // Upper byte enables, low drives
    output logic [7:0] ser_pins_out,               // Lower byte levels to serial engine
    input wire logic [7:0] ser_pins_in,            // Serial engine drive values
    input wire logic [7:0] ser_pins_oe_n_in        // Serial engine enables, low drives
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [HISP_SYNC_W-1:0] sync_s;
    logic [15:0] data_s;
    logic cs_s, rd_s, wr_s, cd_s;
    logic [2:0] strap_s;

    hisp_sync #(.WIDTH(HISP_SYNC_W)) u_sync (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .async_in({host_mode_straps_in, cmd_data_select_in, host_wr_in, host_rd_in, host_cs_n_in,
                   host_data_bus_in}),
        .sync_out(sync_s)
    );

    assign data_s = sync_s[HISP_POS_DATA +: HISP_DATA_W];
    assign cs_s = sync_s[HISP_POS_CS];
    assign rd_s = sync_s[HISP_POS_RD];
    assign wr_s = sync_s[HISP_POS_WR];
    assign cd_s = sync_s[HISP_POS_CD];
    assign strap_s = sync_s[HISP_POS_STRAP +: 3];

    // ---------------------------------------------------------------
    // Strap capture
    // ---------------------------------------------------------------
    logic [1:0] settle_q, settle_d;
    logic mode_valid_q, mode_valid_d;
    hisp_mode_t mode_q, mode_d;

    // Wait for the synchroniser to fill, then latch the mode once
    always_comb begin
        settle_d = settle_q;
        mode_valid_d = mode_valid_q;
        mode_d = mode_q;
        if (!mode_valid_q) begin
            if (settle_q == HISP_STRAP_SETTLE) begin
                mode_valid_d = 1'b1;
                mode_d = hisp_decode(strap_s);
            end else begin
                settle_d = settle_q + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            settle_q <= 2'h0;
            mode_valid_q <= 1'b0;
            mode_q <= HISP_MODE_8080;
        end else begin
            settle_q <= settle_d;
            mode_valid_q <= mode_valid_d;
            mode_q <= mode_d;
        end
    end

    logic par_w, ser_w, is6800_w;
    assign par_w = mode_valid_q && hisp_is_par(mode_q);
    assign ser_w = mode_valid_q && !hisp_is_par(mode_q);
    assign is6800_w = (mode_q == HISP_MODE_6800);

    // ---------------------------------------------------------------
    // Parallel cycle decode
    // ---------------------------------------------------------------
    logic rd_req_w, wr_req_w, act_w;

    // Strobe meaning depends on the bus style
    always_comb begin
        if (is6800_w) begin
            rd_req_w = rd_s && wr_s;
            wr_req_w = rd_s && !wr_s;
        end else begin
            rd_req_w = !rd_s;
            wr_req_w = !wr_s && rd_s;
        end
        act_w = par_w && !cs_s && (rd_req_w || wr_req_w);
    end

    // ---------------------------------------------------------------
    // Cycle engine
    // ---------------------------------------------------------------
    hisp_state_t state_q, state_d;
    logic is_rd_q, is_rd_d, cd_q, cd_d, wait_q, wait_d, drv_q, drv_d;
    logic cmd_wr_q, cmd_wr_d, data_wr_q, data_wr_d, st_rd_q, st_rd_d, dat_rd_q, dat_rd_d;
    logic [15:0] wdat_q, wdat_d, rdat_q, rdat_d;

    // Take a cycle, hold wait low until the core can finish, then wait for release
    always_comb begin
        state_d = state_q;
        is_rd_d = is_rd_q;
        cd_d = cd_q;
        wait_d = wait_q;
        drv_d = drv_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        cmd_wr_d = 1'b0;
        data_wr_d = 1'b0;
        st_rd_d = 1'b0;
        dat_rd_d = 1'b0;
        case (state_q)
            HISP_ST_IDLE: begin
                wait_d = 1'b1;
                drv_d = 1'b0;
                if (act_w) begin
                    is_rd_d = rd_req_w;
                    cd_d = cd_s;
                    wait_d = 1'b0;
                    state_d = HISP_ST_ACCESS;
                end
            end
            HISP_ST_ACCESS: begin
                if (core_ready_in) begin
                    wait_d = 1'b1;
                    state_d = HISP_ST_HOLD;
                    if (is_rd_q) begin
                        drv_d = 1'b1;
                        rdat_d = cd_q ? rd_data_in : status_in;
                        st_rd_d = !cd_q;
                        dat_rd_d = cd_q;
                    end else begin
                        wdat_d = bus16_en_in ? data_s : {8'h00, data_s[7:0]};
                        cmd_wr_d = !cd_q;
                        data_wr_d = cd_q;
                    end
                end
            end
            HISP_ST_HOLD: begin
                if (!act_w) begin
                    drv_d = 1'b0;
                    state_d = HISP_ST_IDLE;
                end
            end
            default: begin
                state_d = HISP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= HISP_ST_IDLE;
            is_rd_q <= 1'b0;
            cd_q <= 1'b0;
            wait_q <= 1'b1;
            drv_q <= 1'b0;
            wdat_q <= 16'h0000;
            rdat_q <= 16'h0000;
            cmd_wr_q <= 1'b0;
            data_wr_q <= 1'b0;
            st_rd_q <= 1'b0;
            dat_rd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            is_rd_q <= is_rd_d;
            cd_q <= cd_d;
            wait_q <= wait_d;
            drv_q <= drv_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            cmd_wr_q <= cmd_wr_d;
            data_wr_q <= data_wr_d;
            st_rd_q <= st_rd_d;
            dat_rd_q <= dat_rd_d;
        end
    end

    // ---------------------------------------------------------------
    // Pin sharing and side signals
    // ---------------------------------------------------------------
    logic [15:0] bus_d, bus_q, oe_n_d, oe_n_q;
    logic [3:0] aux_d, aux_q;
    logic ext_d, ext_q, int_n_q;

    // Lower byte to serial engine or read data, upper byte to read data or general port
    always_comb begin
        if (ser_w) begin
            bus_d[7:0] = ser_pins_in;
            oe_n_d[7:0] = ser_pins_oe_n_in;
        end else begin
            bus_d[7:0] = rdat_d[7:0];
            oe_n_d[7:0] = drv_d ? 8'h00 : HISP_BYTE_HIZ;
        end
        if (par_w && bus16_en_in) begin
            bus_d[15:8] = rdat_d[15:8];
            oe_n_d[15:8] = drv_d ? 8'h00 : HISP_BYTE_HIZ;
        end else begin
            bus_d[15:8] = upper_bus_io_port_in;
            oe_n_d[15:8] = upper_bus_io_oe_n_in;
        end
        aux_d = ser_w ? {cd_s, wr_s, rd_s, cs_s} : 4'h0;
        ext_d = par_w && strap_s[0];
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bus_q <= 16'h0000;
            oe_n_q <= 16'hffff;
            aux_q <= 4'h0;
            ext_q <= 1'b0;
            int_n_q <= 1'b1;
        end else begin
            bus_q <= bus_d;
            oe_n_q <= oe_n_d;
            aux_q <= aux_d;
            ext_q <= ext_d;
            int_n_q <= !irq_req_in;
        end
    end

    assign host_data_bus_out = bus_q;
    assign host_data_bus_oe_n_out = oe_n_q;
    assign wait_out = wait_q;
    assign int_n_out = int_n_q;
    assign host_mode_out = mode_q;
    assign mode_valid_out = mode_valid_q;
    assign ext_irq_out = ext_q;
    assign cmd_wr_out = cmd_wr_q;
    assign data_wr_out = data_wr_q;
    assign status_rd_out = st_rd_q;
    assign data_rd_out = dat_rd_q;
    assign wr_data_out = wdat_q;
    assign aux_input_port_out = aux_q;
    assign upper_bus_io_port_out = data_s[15:8];
    assign ser_pins_out = data_s[7:0];

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_take;
        state_q == HISP_ST_IDLE && act_w;
    endsequence

    sequence s_stall;
        !core_ready_in && !wait_q;
    endsequence

    sequence s_done;
        wait_q && $onehot({cmd_wr_q, data_wr_q, st_rd_q, dat_rd_q});
    endsequence

    a_mode_decode: assert property ($rose(mode_valid_q) |-> mode_q == hisp_decode($past(strap_s)))
        else $error("mode does not match straps");
    a_mode_fixed: assert property (mode_valid_q |=> mode_valid_q && $stable(mode_q))
        else $error("mode changed after capture");
    a_ext_irq: assert property (par_w |=> ext_irq_out == $past(strap_s[0]))
        else $error("external interrupt not following strap");
    a_upper_gpio: assert property (mode_valid_q && !bus16_en_in |=>
        host_data_bus_oe_n_out[15:8] == $past(upper_bus_io_oe_n_in))
        else $error("upper byte not given to general port");
    a_serial_pins: assert property (ser_w |=> host_data_bus_oe_n_out[7:0] == $past(ser_pins_oe_n_in))
        else $error("lower byte not given to serial engine");
    a_cs_gate: assert property (state_q == HISP_ST_IDLE && cs_s |=> state_q == HISP_ST_IDLE && wait_out)
        else $error("cycle taken without chip select");
    a_wait_stall: assert property (s_take |=> !wait_out ##0 s_stall [*2] |=> !wait_out)
        else $error("wait released before core ready");
    a_wait_done: assert property (state_q == HISP_ST_ACCESS && core_ready_in |=> s_done ##1 wait_out)
        else $error("wait not raised on completion");
    a_cmd_write: assert property (cmd_wr_out || status_rd_out |-> !cd_q && state_q == HISP_ST_HOLD)
        else $error("command cycle with select high");
    a_data_cycle: assert property (data_wr_out || data_rd_out |-> cd_q && state_q == HISP_ST_HOLD)
        else $error("data cycle with select low");
    a_aux_inputs: assert property (ser_w |=> aux_input_port_out == $past({cd_s, wr_s, rd_s, cs_s}))
        else $error("auxiliary inputs wrong");
    a_read_strobe: assert property ((s_take and (!is6800_w && rd_s)) |=> !is_rd_q)
        else $error("8080 write taken as read");
    a_6800_dir: assert property ((s_take and is6800_w) |=> is_rd_q == $past(wr_s))
        else $error("6800 direction wrong");

endmodule
`default_nettype wire

// >>> tb/hisp_host_model.sv
/*
 * Model of the host microcontroller on the parallel bus of the port.
 * Assumes the bench resolves the data bus from all drivers.
 */
`timescale 1ns/1ps
`default_nettype none
module hisp_host_model (
    input wire logic mclk_in,        // Bench clock
    input wire logic wait_in,        // Wait pin, high when ready
    input wire logic [15:0] bus_in,  // Resolved data bus
    output logic cs_n_out,           // Chip select, active low
    output logic rd_out,             // Read or enable pin
    output logic wr_out,             // Write or direction pin
    output logic sel_out,            // Command/data select pin
    output logic drv_out,            // Host drives the bus
    output logic [15:0] data_out     // Host drive value
);
    // Control pins rest at their pulled-up level
    initial begin
        cs_n_out = 1'b1;
        rd_out = 1'b1;
        wr_out = 1'b1;
        sel_out = 1'b1;
        drv_out = 1'b0;
        data_out = 16'h0;
    end

    // One bus cycle; ok tells whether the device answered
    task automatic xfer(input logic m68, input logic rd, input logic sel, input logic csn,
                        input logic [15:0] d, output logic [15:0] q, output logic ok);
        int n;
        @(posedge mclk_in);
        cs_n_out <= csn;
        sel_out <= sel;
        rd_out <= m68 | !rd;
        wr_out <= rd;
        drv_out <= !rd;
        data_out <= d;
        n = 0;
        // Bounded look for the wait pin to fall
        while (wait_in !== 1'b0 && n < 8) begin
            @(posedge mclk_in);
            n++;
        end
        n = 0;
        // Hold the cycle while wait stays low, for at most 300 cycles
        while (wait_in === 1'b0 && n < 300) begin
            @(posedge mclk_in);
            n++;
        end
        ok = (n > 0) && (wait_in === 1'b1);
        q = bus_in;
        cs_n_out <= 1'b1;
        rd_out <= !m68;
        wr_out <= 1'b1;
        drv_out <= 1'b0;
        repeat (5) @(posedge mclk_in);
    endtask

    // Plain levels on the control pins and the bus
    task automatic set_pins(input logic [3:0] v, input logic [15:0] d);
        @(posedge mclk_in);
        {sel_out, wr_out, rd_out, cs_n_out} <= v;
        drv_out <= 1'b1;
        data_out <= d;
    endtask
endmodule
`default_nettype wire

// >>> tb/host_interface_select_port_tb.sv
/*
 * Self-checking bench of the host interface select port.
 * Assumes the package, the port and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module host_interface_select_port_tb;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [2:0] straps = 3'h0;
    logic irq = 1'b0;
    logic b16 = 1'b0;
    logic rdy = 1'b1;
    logic [15:0] stat = 16'h0;
    logic [15:0] rdat = 16'h0;
    logic [31:0] st = 32'h0000a50e; // Seed 42254
    logic [7:0] cyc = 8'h0;
    int n_errors = 0;
    int samples_checked = 0;
    int pc[4] = '{0, 0, 0, 0};
    logic [15:0] dout, oe_n, wr_data, hdat, bus;
    logic wt, int_n, mv, ext, cs_n, rd, wr, sel, drv;
    logic [2:0] mode;
    logic [3:0] pv, aux;
    logic [7:0] up, ser;
    logic [7:0] gpo = 8'h00, gpe = 8'hff, spo = 8'h00, spe = 8'hff;

    // Wire level: device drive, else host, else inverse of last host value
    assign bus = (dout & ~oe_n) | ((drv ? hdat : ~hdat) & oe_n);

    always #10 mclk_in = ~mclk_in;

    // Core readiness with short and long stalls; pulse counters
    always @(posedge mclk_in) begin
        cyc <= cyc + 8'h1;
        rdy <= (cyc[2:0] != 3'h0) && !(cyc[5] && cyc[4]);
        for (int i = 0; i < 4; i++) begin
            pc[i] <= pc[i] + int'(pv[i]);
        end
    end

    hisp_port hisp_port_i (.mclk_in(mclk_in), .resetn_in(resetn_in), .host_mode_straps_in(straps),
        .host_cs_n_in(cs_n), .host_rd_in(rd), .host_wr_in(wr), .cmd_data_select_in(sel),
        .host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe_n_out(oe_n),
        .wait_out(wt), .int_n_out(int_n), .irq_req_in(irq), .bus16_en_in(b16),
        .host_mode_out(mode), .mode_valid_out(mv), .ext_irq_out(ext), .core_ready_in(rdy),
        .status_in(stat), .rd_data_in(rdat), .cmd_wr_out(pv[0]), .data_wr_out(pv[1]),
        .status_rd_out(pv[2]), .data_rd_out(pv[3]), .wr_data_out(wr_data),
        .aux_input_port_out(aux), .upper_bus_io_port_out(up), .upper_bus_io_port_in(gpo),
        .upper_bus_io_oe_n_in(gpe), .ser_pins_out(ser), .ser_pins_in(spo),
        .ser_pins_oe_n_in(spe));

    hisp_host_model hisp_host_model_i (.mclk_in(mclk_in), .wait_in(wt), .bus_in(bus),
        .cs_n_out(cs_n), .rd_out(rd), .wr_out(wr), .sel_out(sel), .drv_out(drv), .data_out(hdat));

    // Xorshift source of stimulus
    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction

    // Mode code expected from a strap value
    function automatic logic [2:0] exp_mode(input logic [2:0] s);
        if (s[2:1] == 2'h3) return 3'h4;
        if (s[2]) return {2'h1, s[0]};
        return {2'h0, s[1]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Reset with given straps, then wait for the mode capture
    task automatic do_reset(input logic [2:0] s);
        int n;
        resetn_in <= 1'b0;
        straps <= s;
        repeat (4) @(posedge mclk_in);
        chk(oe_n, 16'hffff, "bus released in reset");
        chk({14'h0, wt, int_n}, 16'h3, "wait and interrupt in reset");
        resetn_in <= 1'b1;
        n = 0;
        while (mv !== 1'b1 && n < 12) begin
            @(posedge mclk_in);
            n++;
        end
        chk({12'h0, mv, mode}, {12'h0, 1'b1, exp_mode(s)}, "mode capture");
    endtask

    // One host cycle with random data; en says whether the device must answer
    task automatic run(input logic m68, input logic r, input logic s, input logic csn, input logic en);
        logic [31:0] t;
        logic [15:0] d, q, e, m, g;
        logic ok;
        int b[4];
        t = rnd();
        d = t[15:0];
        stat <= t[31:16];
        rdat <= ~t[15:0];
        b16 <= t[16];
        irq <= t[17];
        b = pc;
        hisp_host_model_i.xfer(m68, r, s, csn, d, q, ok);
        m = b16 ? 16'hffff : 16'h00ff;
        e = r ? (s ? rdat : stat) : d;
        for (int i = 0; i < 4; i++) begin
            g[i*4 +: 4] = 4'(pc[i] - b[i]);
        end
        chk({15'h0, ok}, {15'h0, en}, "wait handshake");
        chk(g, en ? 16'h1 << (4 * {r, s}) : 16'h0, "cycle kind");
        if (en && r) chk(q & m, e & m, "read word");
        if (en && !r) chk(wr_data, e & m, "write word");
        chk({15'h0, int_n}, {15'h0, !irq}, "interrupt pin");
    endtask

    // Every strap code, then its cycles, each after a set of plain inputs in serial modes
    initial begin
        logic [31:0] r, v;
        logic [15:0] e;
        for (int s = 0; s < 8; s++) begin
            do_reset(3'(s));
            r = rnd();
            straps <= r[2:0];
            repeat (6) @(posedge mclk_in);
            chk({13'h0, mode}, {13'h0, exp_mode(3'(s))}, "mode held");
            chk({15'h0, ext}, {15'h0, (s < 4) & r[0]}, "external interrupt");
            for (int k = 0; k < 9; k++) begin
                if (s >= 4) begin
                    r = rnd();
                    v = rnd();
                    // Serial engine and general port drive their bytes with random enables
                    {gpo, gpe, spo, spe} <= v;
                    hisp_host_model_i.set_pins(r[3:0], r[31:16]);
                    repeat (5) @(posedge mclk_in);
                    chk({12'h0, aux}, {12'h0, r[3:0]}, "aux inputs");
                    e = ({v[31:24], v[15:8]} & ~{v[23:16], v[7:0]}) | (r[31:16] & {v[23:16], v[7:0]});
                    chk({up, ser}, e, "serial and upper pins");
                end
                run(s >= 2, k[1], k[0], k == 8, (s < 4) && (k != 8));
            end
        end
        conclude();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge mclk_in);
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
